// [verilog/jog_limit_pkg.sv]
// Purpose: Shared constants, types and helpers for the jog and limit motion block
// Assumes: 125 MHz system clock, speeds in signed rpm, ramp times in milliseconds
// Notes: Register offsets are byte addresses on the plain register port
package jog_limit_pkg;
    // ------------------------------------------------------------------
    // Widths and types
    // ------------------------------------------------------------------
    localparam int DATA_W = 16;
    localparam int ADDR_W = 8;
    localparam int DIN_W = 8;
    localparam int SRC_W = 3;
    localparam int ACC_W = 40;
    typedef logic signed [DATA_W-1:0] speed_type;
    typedef logic [DATA_W-1:0] word_type;
    typedef enum {ST_IDLE, ST_JOG_RUN, ST_JOG_STOP, ST_LIM_RUN, ST_LIM_STOP} motion_state_type;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_JOG1 = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_JOG2 = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_MAX = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_RAMP_UP = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_RAMP_DOWN = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_QUICK = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_LIM_SP = 8'h1c;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_SPEED = 8'h24;
    localparam logic [ADDR_W-1:0] OFS_STATE = 8'h28;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CTRL_LIMIT_EN = 0;
    localparam int CTRL_NEG_INH = 1;
    localparam int CTRL_POS_INH = 2;
    localparam int CTRL_INVERT = 3;
    localparam int CTRL_SRC1_LSB = 8;
    localparam int CTRL_SRC2_LSB = 12;
    localparam int STAT_ON = 0;
    localparam int STAT_NO_QUICK = 1;
    localparam int STAT_STANDSTILL = 2;
    localparam int STAT_POS_ACT = 4;
    localparam int STAT_NEG_ACT = 5;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam word_type RST_CTRL = 16'h1000;
    localparam word_type RST_JOG1 = 16'h0096;
    localparam word_type RST_JOG2 = 16'hff6a;
    localparam word_type RST_MAX = 16'h05dc;
    localparam word_type RST_RAMP_UP = 16'h2710;
    localparam word_type RST_RAMP_DOWN = 16'h2710;
    localparam word_type RST_QUICK = 16'h03e8;
    localparam word_type RST_LIM_SP = 16'h0096;
    localparam word_type RST_STATUS = 16'h0006;
    localparam word_type CTRL_RD_MASK = 16'h770f;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int RAMP_UNIT_NS = 1000000;
    localparam int CYCLES_PER_MS = RAMP_UNIT_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Negation that keeps the most negative value in range
    function automatic speed_type neg_sat(input speed_type v);
        neg_sat = (v == 16'sh8000) ? 16'sh7fff : -v;
    endfunction

    // Magnitude limit to a configured maximum
    function automatic speed_type clamp_speed(input speed_type v, input word_type lim);
        logic signed [DATA_W:0] l;
        logic signed [DATA_W:0] x;
        l = (lim[DATA_W-1]) ? 17'sh07fff : $signed({1'b0, lim});
        x = {v[DATA_W-1], v};
        if (x > l)
            clamp_speed = speed_type'(l[DATA_W-1:0]);
        else if (x < -l)
            clamp_speed = neg_sat(speed_type'(l[DATA_W-1:0]));
        else
            clamp_speed = v;
    endfunction

    // Cycles for a full swing from zero to the maximum speed
    function automatic logic [ACC_W-1:0] ramp_period(input word_type t_ms, input int cyc);
        ramp_period = ACC_W'(t_ms) * ACC_W'(cyc);
    endfunction
endpackage

// [verilog/ramp_if.sv]
// Purpose: Link between the motion control and its ramp generator
// Assumes: Single clock domain
// Notes: Control side sets the target and times, ramp side returns the reference
`timescale 1ns/10ps
interface ramp_if;
    import jog_limit_pkg::*;
    speed_type target;
    logic quick;
    word_type max_speed;
    word_type up_ms;
    word_type down_ms;
    word_type quick_ms;
    speed_type speed;
    logic standstill;
    modport ctrl(output target, quick, max_speed, up_ms, down_ms, quick_ms, input speed, standstill);
    modport gen(input target, quick, max_speed, up_ms, down_ms, quick_ms, output speed, standstill);
endinterface

// [verilog/ramp_gen.sv]
// Purpose: Ramp generator stepping the speed reference by one rpm at a time
// Assumes: Ramp time is the time for a swing from zero to maximum speed
// Notes: Quick ramp time replaces the down time while a quick stop is asked
`timescale 1ns/10ps
module ramp_gen #(
    parameter int CYC_PER_MS = 125000
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    // Ramp link
    ramp_if.gen rif
);
    import jog_limit_pkg::*;

    logic [ACC_W-1:0] acc;
    speed_type speed;
    logic standstill;

    // ------------------------------------------------------------------
    // Direction and step decision
    // ------------------------------------------------------------------
    wire logic at_target = (rif.target == speed);
    wire logic go_up = (rif.target > speed);
    wire logic away_from_zero = go_up ? (speed >= 0) : (speed <= 0);
    wire word_type sel_ms = away_from_zero ? rif.up_ms : (rif.quick ? rif.quick_ms : rif.down_ms);
    wire logic [ACC_W-1:0] period = ramp_period(sel_ms, CYC_PER_MS);
    wire logic [ACC_W-1:0] acc_sum = acc + {{(ACC_W-DATA_W){1'b0}}, rif.max_speed};
    wire logic step = !at_target && (acc_sum >= period);
    wire logic [ACC_W-1:0] next_acc = at_target ? '0 : (step ? acc_sum - period : acc_sum);
    wire speed_type next_speed = step ? (go_up ? speed + 16'sh0001 : speed - 16'sh0001) : speed;

    // Reference and accumulator update
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            acc <= '0;
            speed <= '0;
            standstill <= 1'b1;
        end
        else
        begin
            acc <= next_acc;
            speed <= next_speed;
            standstill <= (next_speed == 0);
        end
    end

    assign rif.speed = speed;
    assign rif.standstill = standstill;
endmodule

// [verilog/jog_limit_motion.sv]
// Purpose: Jog and limit position motion command logic with register port
// Assumes: Inputs synchronous to clk_sys_i, speeds in signed rpm
// Notes: Summary of operation below
//
// Summary of operation
// - A jog command switches the motor on; dropping it switches it off.
// - Jog commands are taken only while the drive is ready to switch on.
// - After switch-on the motor ramps toward the active jog setpoint.
// - Jogging uses the same ramp generator as normal on and ramp stop.
// - Two jog setpoints, defaults plus 150 rpm and minus 150 rpm.
// - Speed reference magnitude is limited to a maximum, default 1500 rpm.
// - Negative inhibit at 1 blocks negative rotation; 0 allows it.
// - Positive inhibit at 1 blocks positive rotation; 0 allows it.
// - Inversion at 1 negates the setpoint; 0 passes it unchanged.
// - Ramp-up time configurable, default 10 s.
// - Ramp-down time configurable, default 10 s.
// - Jog selects default to digital inputs 0 and 1, both reassignable.
// - Reaching a limit position stops the motor on the quick ramp.
// - At one limit, a new command moves toward the opposite limit.
// - A motion command is a rising edge of the start input.
// - With no limit active, setpoint sign picks the first direction.
// - Status bit 0 is 1 while limit logic commands on, 0 on ramp stop.
// - Status bit 1 is 1 with no quick stop, 0 while quick stop asked.
// - Status bit 2 is 1 while the axis stands still.
// - Status bits 4 and 5 show positive and negative limit actuated.
//
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/10ps
module jog_limit_motion #(
    parameter int CYC_PER_MS = jog_limit_pkg::CYCLES_PER_MS
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    // Register port
    input wire logic [jog_limit_pkg::ADDR_W-1:0] addr_i,
    input wire jog_limit_pkg::word_type wr_data_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output jog_limit_pkg::word_type rd_data_o,
    // Local command inputs
    input wire logic [jog_limit_pkg::DIN_W-1:0] din_i,
    input wire logic ready_to_switch_on_i,
    input wire logic limit_start_input_i,
    input wire logic negative_limit_input_n_i,
    input wire logic positive_limit_input_n_i,
    // Drive command outputs
    output logic motor_on_o,
    output logic quick_ramp_stop_o,
    output jog_limit_pkg::speed_type speed_ref_o,
    output jog_limit_pkg::word_type limit_status_word_o
);
    import jog_limit_pkg::*;

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    word_type ctrl;
    word_type first_jog_speed_setpoint;
    word_type second_jog_speed_setpoint;
    word_type max_speed_limit;
    word_type ramp_up_time;
    word_type ramp_down_time;
    word_type quick_ramp_time;
    word_type limit_speed_setpoint;

    // ------------------------------------------------------------------
    // Control state
    // ------------------------------------------------------------------
    motion_state_type state;
    motion_state_type next_state;
    logic jog_second;
    logic next_jog_second;
    logic lim_dir_pos;
    logic next_lim_dir_pos;
    logic start_q;
    word_type status;

    ramp_if rif();

    // ------------------------------------------------------------------
    // Control field decode
    // ------------------------------------------------------------------
    wire logic limit_enable = ctrl[CTRL_LIMIT_EN];
    wire logic negative_direction_inhibit = ctrl[CTRL_NEG_INH];
    wire logic positive_direction_inhibit = ctrl[CTRL_POS_INH];
    wire logic setpoint_invert = ctrl[CTRL_INVERT];
    wire logic [SRC_W-1:0] first_jog_select_source = ctrl[CTRL_SRC1_LSB +: SRC_W];
    wire logic [SRC_W-1:0] second_jog_select_source = ctrl[CTRL_SRC2_LSB +: SRC_W];

    // ------------------------------------------------------------------
    // Jog select routing
    // ------------------------------------------------------------------
    // Each select picks one digital input by index
    wire logic jog1 = din_i[first_jog_select_source];
    wire logic jog2 = din_i[second_jog_select_source];
    wire logic jog_valid = jog1 ^ jog2;
    wire logic jog_held = jog_second ? (jog2 && !jog1) : (jog1 && !jog2);

    // ------------------------------------------------------------------
    // Limit inputs and start edge
    // ------------------------------------------------------------------
    // Switches pull low when actuated
    wire logic pos_limit = !positive_limit_input_n_i;
    wire logic neg_limit = !negative_limit_input_n_i;
    // Only a low-to-high change starts motion, a held high does nothing
    wire logic start_rise = limit_start_input_i && !start_q;

    // ------------------------------------------------------------------
    // Setpoint chain
    // ------------------------------------------------------------------
    // Raw setpoint of the active function
    wire speed_type jog_raw = jog_second ? speed_type'(second_jog_speed_setpoint) :
                                           speed_type'(first_jog_speed_setpoint);
    wire speed_type jog_inv = setpoint_invert ? neg_sat(jog_raw) : jog_raw;
    wire speed_type lim_inv = setpoint_invert ? neg_sat(speed_type'(limit_speed_setpoint)) :
                                                speed_type'(limit_speed_setpoint);
    // Limit speed magnitude, latched direction adds the sign
    wire speed_type lim_mag = lim_inv[DATA_W-1] ? neg_sat(lim_inv) : lim_inv;
    wire speed_type lim_dir_sp = lim_dir_pos ? lim_mag : neg_sat(lim_mag);
    wire logic jog_phase = (state == ST_JOG_RUN);
    wire logic lim_phase = (state == ST_LIM_RUN);
    wire speed_type run_sp = jog_phase ? jog_inv : (lim_phase ? lim_dir_sp : 16'sh0000);
    wire speed_type run_clamped = clamp_speed(run_sp, max_speed_limit);
    // Inhibited direction gives zero regardless of source
    wire logic sp_blocked = (run_clamped < 0 && negative_direction_inhibit) ||
                            (run_clamped > 0 && positive_direction_inhibit);
    wire speed_type target_sp = sp_blocked ? 16'sh0000 : run_clamped;

    // ------------------------------------------------------------------
    // Limit direction decision
    // ------------------------------------------------------------------
    // At a limit head for the other one; otherwise follow the setpoint sign
    wire logic start_dir_pos = pos_limit ? 1'b0 : (neg_limit ? 1'b1 : !lim_inv[DATA_W-1]);
    wire logic start_allowed = limit_enable && !(pos_limit && neg_limit) && ready_to_switch_on_i;
    wire logic limit_hit = lim_dir_pos ? pos_limit : neg_limit;

    // ------------------------------------------------------------------
    // Motion sequencer
    // ------------------------------------------------------------------
    // Next state and latched selections
    always_comb
    begin
        next_state = state;
        next_jog_second = jog_second;
        next_lim_dir_pos = lim_dir_pos;
        case (state)
            ST_IDLE:
            begin
                // Jog accepted only in the ready state, otherwise ignored
                if (ready_to_switch_on_i && jog_valid)
                begin
                    next_state = ST_JOG_RUN;
                    next_jog_second = jog2;
                end
                else if (start_rise && start_allowed)
                begin
                    next_state = ST_LIM_RUN;
                    next_lim_dir_pos = start_dir_pos;
                end
            end
            ST_JOG_RUN:
            begin
                if (!jog_held)
                    next_state = ST_JOG_STOP;
            end
            ST_JOG_STOP:
            begin
                // Normal ramp down, then switch off
                if (rif.standstill)
                    next_state = ST_IDLE;
            end
            ST_LIM_RUN:
            begin
                if (limit_hit)
                    next_state = ST_LIM_STOP;
                else if (!limit_enable)
                    next_state = ST_JOG_STOP;
            end
            ST_LIM_STOP:
            begin
                if (rif.standstill)
                    next_state = ST_IDLE;
            end
            default:
            begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // State registers
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            state <= ST_IDLE;
            jog_second <= 1'b0;
            lim_dir_pos <= 1'b1;
            start_q <= 1'b0;
        end
        else
        begin
            state <= next_state;
            jog_second <= next_jog_second;
            lim_dir_pos <= next_lim_dir_pos;
            start_q <= limit_start_input_i;
        end
    end

    // ------------------------------------------------------------------
    // Ramp generator
    // ------------------------------------------------------------------
    // Jog and limit share one generator
    assign rif.target = target_sp;
    assign rif.quick = (state == ST_LIM_STOP);
    assign rif.max_speed = max_speed_limit;
    assign rif.up_ms = ramp_up_time;
    assign rif.down_ms = ramp_down_time;
    assign rif.quick_ms = quick_ramp_time;

    // Shared ramp generator instance
    ramp_gen #(
        .CYC_PER_MS(CYC_PER_MS)
    ) u_ramp (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .rif(rif)
    );

    // ------------------------------------------------------------------
    // Limit status word
    // ------------------------------------------------------------------
    // Live flags, unused bits held at zero
    wire word_type next_status = {10'h000,
                                  neg_limit,
                                  pos_limit,
                                  1'b0,
                                  rif.standstill,
                                  !rif.quick,
                                  lim_phase};

    // Drive command outputs
    wire logic next_motor_on = (state != ST_IDLE);

    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            status <= RST_STATUS;
            motor_on_o <= 1'b0;
            quick_ramp_stop_o <= 1'b0;
            speed_ref_o <= '0;
        end
        else
        begin
            status <= next_status;
            motor_on_o <= next_motor_on;
            quick_ramp_stop_o <= rif.quick;
            speed_ref_o <= rif.speed;
        end
    end

    assign limit_status_word_o = status;

    // ------------------------------------------------------------------
    // Register write decode
    // ------------------------------------------------------------------
    // One strobe per register, full address compare
    wire logic wr_ctrl = wr_i && (addr_i == OFS_CTRL);
    wire logic wr_jog1 = wr_i && (addr_i == OFS_JOG1);
    wire logic wr_jog2 = wr_i && (addr_i == OFS_JOG2);
    wire logic wr_max = wr_i && (addr_i == OFS_MAX);
    wire logic wr_up = wr_i && (addr_i == OFS_RAMP_UP);
    wire logic wr_down = wr_i && (addr_i == OFS_RAMP_DOWN);
    wire logic wr_quick = wr_i && (addr_i == OFS_QUICK);
    wire logic wr_lim_sp = wr_i && (addr_i == OFS_LIM_SP);

    // Configuration storage
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            ctrl <= RST_CTRL;
            first_jog_speed_setpoint <= RST_JOG1;
            second_jog_speed_setpoint <= RST_JOG2;
            max_speed_limit <= RST_MAX;
            ramp_up_time <= RST_RAMP_UP;
            ramp_down_time <= RST_RAMP_DOWN;
            quick_ramp_time <= RST_QUICK;
            limit_speed_setpoint <= RST_LIM_SP;
        end
        else
        begin
            if (wr_ctrl)
                ctrl <= wr_data_i;
            if (wr_jog1)
                first_jog_speed_setpoint <= wr_data_i;
            if (wr_jog2)
                second_jog_speed_setpoint <= wr_data_i;
            if (wr_max)
                max_speed_limit <= wr_data_i;
            if (wr_up)
                ramp_up_time <= wr_data_i;
            if (wr_down)
                ramp_down_time <= wr_data_i;
            if (wr_quick)
                quick_ramp_time <= wr_data_i;
            if (wr_lim_sp)
                limit_speed_setpoint <= wr_data_i;
        end
    end

    // ------------------------------------------------------------------
    // Register read path
    // ------------------------------------------------------------------
    // Unused control bits read as zero; unmapped addresses read zero
    wire word_type ctrl_rd = ctrl & CTRL_RD_MASK;
    wire word_type state_rd = {13'h0000, 3'(state)};
    wire word_type rd_sel = (addr_i == OFS_CTRL) ? ctrl_rd :
                            (addr_i == OFS_JOG1) ? first_jog_speed_setpoint :
                            (addr_i == OFS_JOG2) ? second_jog_speed_setpoint :
                            (addr_i == OFS_MAX) ? max_speed_limit :
                            (addr_i == OFS_RAMP_UP) ? ramp_up_time :
                            (addr_i == OFS_RAMP_DOWN) ? ramp_down_time :
                            (addr_i == OFS_QUICK) ? quick_ramp_time :
                            (addr_i == OFS_LIM_SP) ? limit_speed_setpoint :
                            (addr_i == OFS_STATUS) ? status :
                            (addr_i == OFS_SPEED) ? word_type'(speed_ref_o) :
                            (addr_i == OFS_STATE) ? state_rd : 16'h0000;

    // Read data stands one cycle after the strobe only
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
            rd_data_o <= '0;
        else
            rd_data_o <= rd_i ? rd_sel : 16'h0000;
    end
endmodule

// [sim/jlm_props.sv]
// Purpose: Assertions on the jog and limit block ports
// Assumes: Default jog select sources
// Notes: Attached by the bind below
`timescale 1ns/10ps
module jlm_props import jog_limit_pkg::*; (
    // Watched ports
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic [DIN_W-1:0] din_i,
    input wire logic ready_to_switch_on_i,
    input wire logic negative_limit_input_n_i,
    input wire logic positive_limit_input_n_i,
    input wire logic motor_on_o,
    input wire logic quick_ramp_stop_o,
    input wire speed_type speed_ref_o,
    input wire word_type limit_status_word_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!nrst_i);
    // Status follows switches, stop and switch-on state
    property p_pos_bit; 1 |=> limit_status_word_o[4] == !$past(positive_limit_input_n_i); endproperty
    a_pos_bit: assert property (p_pos_bit) else $error("plus limit bit wrong");
    property p_neg_bit; 1 |=> limit_status_word_o[5] == !$past(negative_limit_input_n_i); endproperty
    a_neg_bit: assert property (p_neg_bit) else $error("minus limit bit wrong");
    property p_run_on; limit_status_word_o[0] |-> motor_on_o; endproperty
    a_run_on: assert property (p_run_on) else $error("run bit without motor on");
    property p_quick_bit; limit_status_word_o[1] != quick_ramp_stop_o; endproperty
    a_quick_bit: assert property (p_quick_bit) else $error("quick bit wrong");
    property p_off_zero; !motor_on_o |-> speed_ref_o == 0 && limit_status_word_o[2]; endproperty
    a_off_zero: assert property (p_off_zero) else $error("speed while off");
    property p_not_ready; !ready_to_switch_on_i ##1 !motor_on_o |=> !motor_on_o; endproperty
    a_not_ready: assert property (p_not_ready) else $error("start while not ready");
    property p_both_sel; din_i[1:0] == 2'h3 ##1 !motor_on_o |=> !motor_on_o; endproperty
    a_both_sel: assert property (p_both_sel) else $error("start on both selects");
    property p_quick_cause; $rose(quick_ramp_stop_o) |-> !(positive_limit_input_n_i && negative_limit_input_n_i);
    endproperty
    a_quick_cause: assert property (p_quick_cause) else $error("quick stop without limit");
endmodule
bind jog_limit_motion jlm_props i_jlm_props (.clk_sys_i, .nrst_i, .din_i, .ready_to_switch_on_i,
    .negative_limit_input_n_i, .positive_limit_input_n_i, .motor_on_o, .quick_ramp_stop_o,
    .speed_ref_o, .limit_status_word_o);

// [sim/limit_axis_model.sv]
// Purpose: Axis with two end switches and a start input
// Assumes: Position grows by the speed reference each cycle
// Notes: Switches stay pulled low while past their end
`timescale 1ns/10ps
module limit_axis_model import jog_limit_pkg::*; #(
    parameter int END_POS = 1000000
) (
    input wire logic clk_sys_i,
    input wire speed_type speed_ref_i,
    input wire logic start_req_i,
    output logic limit_start_input_o,
    output logic positive_limit_input_n_o,
    output logic negative_limit_input_n_o
);
    int pos = 0;
    // Integrate speed into position
    always @(posedge clk_sys_i)
        pos <= pos + int'(speed_ref_i);
    // Active low switches, active high start
    assign positive_limit_input_n_o = !(pos >= END_POS);
    assign negative_limit_input_n_o = !(pos <= -END_POS);
    assign limit_start_input_o = start_req_i;
endmodule

// [sim/jog_and_limit_motion_control_test.sv]
// Purpose: Self-checking bench for the jog and limit block
// Assumes: One ms of ramp time is one cycle
// Notes: Main flow observes at falling edges
`timescale 1ns/10ps
module jog_and_limit_motion_control_test;
    import jog_limit_pkg::*;
    logic clk_sys_i = 0, nrst_i = 0, wr_i = 0, rd_i = 0, rdy = 0, start = 0, mon, qs, pn, nn, st;
    logic [ADDR_W-1:0] addr_i = '0;
    logic [DIN_W-1:0] din_i = '0;
    word_type wr_data_i = '0, rd_data_o, lsw;
    speed_type spd, mag;
    int n_mismatch = 0, num_checks = 0, cyc = 0;
    word_type ctl [8] = '{16'h1000, 16'h1000, 16'h1008, 16'h1004, 16'h1002, 16'h1000, 16'h1000, 16'h3500};
    logic [7:0] sel [8] = '{8'h01, 8'h02, 8'h02, 8'h01, 8'h02, 8'h03, 8'h01, 8'h08};
    speed_type fin [8] = '{16'sh0096, 16'shff6a, 16'sh0096, 16'sh0000, 16'sh0000, 16'sh0000, 16'sh0000, 16'shff6a};
    always #4 clk_sys_i = !clk_sys_i;
    jog_limit_motion #(.CYC_PER_MS(1)) i_jog_limit_motion (.clk_sys_i, .nrst_i, .addr_i, .wr_data_i,
        .wr_i, .rd_i, .rd_data_o, .din_i, .ready_to_switch_on_i(rdy), .limit_start_input_i(st),
        .negative_limit_input_n_i(nn), .positive_limit_input_n_i(pn), .motor_on_o(mon),
        .quick_ramp_stop_o(qs), .speed_ref_o(spd), .limit_status_word_o(lsw));
    limit_axis_model i_limit_axis_model (.clk_sys_i, .speed_ref_i(spd), .start_req_i(start),
        .limit_start_input_o(st), .positive_limit_input_n_o(pn), .negative_limit_input_n_o(nn));
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Hang guard
    always @(posedge clk_sys_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 80000)
        begin
            n_mismatch++;
            report_and_stop();
        end
    end
    task automatic chk(input word_type got, input word_type exp);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input word_type d);
        @(posedge clk_sys_i);
        addr_i <= a;
        wr_data_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input word_type exp);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        @(negedge clk_sys_i);
        chk(rd_data_o, exp);
    endtask
    // Wait for motor off, or for quick stop, within a bound
    task automatic wt(input logic quick, input int lim);
        for (int i = 0; i < lim; i++)
        begin
            @(negedge clk_sys_i);
            if (quick ? qs === 1'b1 : mon === 1'b0)
                break;
        end
        chk(quick ? qs : !mon, 1);
    endtask
    initial
    begin
        repeat (20) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        rd(8'h04, 16'h0096);
        rd(8'h08, 16'hff6a);
        rd(8'h0c, 16'h05dc);
        rd(8'h10, 16'h2710);
        rd(8'h14, 16'h2710);
        rd(8'h3c, 16'h0000);
        $display("register test done");
        for (int k = 0; k < 8; k++)
        begin
            wr(OFS_CTRL, ctl[k]);
            @(posedge clk_sys_i);
            rdy <= k != 6;
            din_i <= sel[k];
            repeat (500) @(negedge clk_sys_i);
            mag = spd < 0 ? -spd : spd;
            chk(mag > 60 && mag < 90, fin[k] != 0);
            repeat (700) @(negedge clk_sys_i);
            chk(spd, fin[k]);
            chk(mon | (fin[k] == 0), 1);
            @(posedge clk_sys_i);
            din_i <= 8'h00;
            wt(0, 1500);
            chk(spd, 0);
            $display("jog case %0d done", k);
        end
        wr(OFS_CTRL, 16'h1001);
        @(posedge clk_sys_i);
        rdy <= 1'b1;
        start <= 1'b1;
        repeat (4) @(negedge clk_sys_i);
        chk(lsw[0], 1);
        repeat (300) @(negedge clk_sys_i);
        chk(spd > 0, 1);
        wt(1, 8000);
        chk(lsw[5:4], 2'h1);
        chk(lsw[1], 0);
        wt(0, 1000);
        chk(lsw[2], 1);
        @(posedge clk_sys_i);
        start <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        start <= 1'b1;
        repeat (300) @(negedge clk_sys_i);
        chk(spd < 0, 1);
        wt(1, 16000);
        chk(lsw[5:4], 2'h2);
        $display("limit test done");
        report_and_stop();
    end
endmodule
